// [rtl/wme_pkg.sv]
// Constants and types for the waveform measurement engine.
// Assumes one 20 MHz clock; samples are 8-bit unsigned codes.
package wme_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int SAMP_W = 8;
   localparam int ADDR_W = 10;
   localparam int BIN_N  = 256;
   localparam int CNT_W  = 11;
   localparam int ACC_W  = 20;
   localparam int SQ_W   = 28;
   localparam int INTV_W = 16;
   localparam int AREA_W = 36;
   localparam int PCT_W  = 7;
   localparam int FRAC_W = 8;
   localparam int TZ_W   = ADDR_W + FRAC_W + 1;
   localparam int BIT_W  = 5;

   // ************************************************************
   // Constant values
   // ************************************************************
   localparam logic [15:0]       PCT_FULL = 16'h0064;
   localparam logic [PCT_W-1:0]  HYST_PCT = 7'h0A;
   localparam logic [SAMP_W-1:0] SAMP_MAX = 8'hFF;
   localparam logic [SAMP_W-1:0] SAMP_MIN = 8'h00;
   localparam logic [SAMP_W-1:0] BIN_LAST = 8'hFF;
   localparam logic [BIT_W-1:0]  DIV_TOP  = 5'h1B;
   localparam logic [BIT_W-1:0]  SQRT_TOP = 5'h07;

   typedef enum {
      S_IDLE, S_CLEAR, S_LOAD, S_HIST, S_LEVEL, S_REFS, S_SCAN, S_POST, S_DIV1, S_DIV2, S_SQRT, S_DONE
   } wme_state_t;

endpackage

// [rtl/wme_engine.sv]
// Waveform measurement engine: levels, crossings, integrals.
// Assumes samples arrive on the same clock, settings stable while busy.
`timescale 1ns/10ps
module wme_engine (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         start,
   input  wire logic                         hist_mode,
   input  wire logic                         gate_enable,
   input  wire logic [wme_pkg::ADDR_W:0]     record_size,
   input  wire logic [wme_pkg::ADDR_W-1:0]   left_cursor,
   input  wire logic [wme_pkg::ADDR_W-1:0]   right_cursor,
   input  wire logic [wme_pkg::PCT_W-1:0]    upper_ref_pct,
   input  wire logic [wme_pkg::PCT_W-1:0]    middle_ref_pct,
   input  wire logic [wme_pkg::PCT_W-1:0]    lower_ref_pct,
   input  wire logic [wme_pkg::PCT_W-1:0]    second_middle_ref_pct,
   input  wire logic [wme_pkg::INTV_W-1:0]   sample_interval,
   input  wire logic                         trigger_strobe,
   input  wire logic [wme_pkg::ADDR_W-1:0]   pretrigger_sample_index,
   input  wire logic [wme_pkg::FRAC_W:0]     trigger_fraction_offset,
   input  wire logic                         sample_valid,
   input  wire logic [wme_pkg::SAMP_W-1:0]   sample_data,
   output logic                              sample_ready,
   output logic                              busy,
   output logic                              done,
   output logic [wme_pkg::SAMP_W-1:0]        high_level,
   output logic [wme_pkg::SAMP_W-1:0]        low_level,
   output logic [wme_pkg::SAMP_W-1:0]        amplitude,
   output logic [wme_pkg::SAMP_W-1:0]        upper_ref_level,
   output logic [wme_pkg::SAMP_W-1:0]        middle_ref_level,
   output logic [wme_pkg::SAMP_W-1:0]        lower_ref_level,
   output logic [wme_pkg::SAMP_W-1:0]        second_middle_ref_level,
   output logic [wme_pkg::ADDR_W-1:0]        first_center_crossing,
   output logic [wme_pkg::ADDR_W-1:0]        second_center_crossing,
   output logic [wme_pkg::ADDR_W-1:0]        third_center_crossing,
   output logic                              first_crossing_polarity,
   output logic                              cycle_valid,
   output logic [wme_pkg::ADDR_W-1:0]        cycle_begin,
   output logic [wme_pkg::ADDR_W-1:0]        cycle_finish,
   output logic [wme_pkg::ADDR_W-1:0]        burst_first_crossing,
   output logic [wme_pkg::ADDR_W-1:0]        burst_last_crossing,
   output logic [wme_pkg::ADDR_W-1:0]        burst_width,
   output logic [wme_pkg::AREA_W-1:0]        area,
   output logic [wme_pkg::AREA_W-1:0]        cycle_area,
   output logic [wme_pkg::SAMP_W-1:0]        cycle_mean,
   output logic [wme_pkg::SAMP_W-1:0]        cycle_rms,
   output logic [wme_pkg::TZ_W-1:0]          time_zero
);
   import wme_pkg::*;

   // ************************************************************
   // Storage and state
   // ************************************************************
   logic [SAMP_W-1:0] rec_mem [0:(1<<ADDR_W)-1];
   logic [CNT_W-1:0]  hist_mem [0:BIN_N-1];
   wme_state_t        state_q;
   logic [ADDR_W:0]   idx_q;
   logic [ADDR_W-1:0] zs_q;
   logic [ADDR_W-1:0] ze_q;
   logic [SAMP_W-1:0] min_q;
   logic [SAMP_W-1:0] max_q;
   logic [SAMP_W-1:0] prev_q;
   logic [SAMP_W-1:0] zs_samp_q;
   logic [SAMP_W-1:0] hyst_q;
   logic [CNT_W-1:0]  hi_cnt_q;
   logic [CNT_W-1:0]  lo_cnt_q;
   logic [SAMP_W-1:0] hi_bin_q;
   logic [SAMP_W-1:0] lo_bin_q;
   logic              rise_arm_q;
   logic              fall_arm_q;
   logic [1:0]        ccnt_q;
   logic [ACC_W-1:0]  area_acc_q;
   logic [ACC_W-1:0]  cyc_acc_q;
   logic [SQ_W-1:0]   sq_acc_q;
   logic [SQ_W-1:0]   div_rem_q;
   logic [SQ_W-1:0]   div_quo_q;
   logic [SQ_W-1:0]   div_den_q;
   logic [BIT_W-1:0]  bit_q;
   // Percent of amplitude above a base level
   function automatic logic [SAMP_W-1:0] pct_level(input logic [SAMP_W-1:0] base,
                                                   input logic [SAMP_W-1:0] amp,
                                                   input logic [PCT_W-1:0]  pct);
      logic [15:0] part;
      part = (16'(amp) * 16'(pct)) / PCT_FULL;
      return SAMP_W'(16'(base) + part);
   endfunction
   // ************************************************************
   // Datapath terms
   // ************************************************************
   logic [SAMP_W-1:0] cur;
   logic [CNT_W-1:0]  bin_cnt;
   logic [CNT_W-1:0]  mid_cnt;
   logic [SAMP_W-1:0] mid_bin;
   logic [SAMP_W-1:0] bin;
   logic              in_zone;
   logic              first_pt;
   logic              rise_x;
   logic              fall_x;
   logic              any_x;
   logic              pol_ok;
   logic              take_x;
   logic              below_band;
   logic              above_band;
   logic [SQ_W-1:0]   rem_sh;
   logic [SAMP_W-1:0] trial;
   logic              last_idx;

   assign bin      = idx_q[SAMP_W-1:0];
   assign cur      = rec_mem[idx_q[ADDR_W-1:0]];
   assign bin_cnt  = hist_mem[bin];
   assign mid_bin  = SAMP_W'((9'(min_q) + 9'(max_q)) >> 1);
   assign mid_cnt  = hist_mem[mid_bin];
   assign in_zone  = idx_q >= (ADDR_W+1)'(zs_q) && idx_q <= (ADDR_W+1)'(ze_q);
   assign last_idx = idx_q == (ADDR_W+1)'(ze_q);
   assign first_pt = idx_q == (ADDR_W+1)'(zs_q);
   // Crossings only count while armed for that direction
   assign rise_x   = !first_pt && prev_q < middle_ref_level && cur >= middle_ref_level && rise_arm_q;
   assign fall_x   = !first_pt && prev_q >= middle_ref_level && cur < middle_ref_level && fall_arm_q;
   assign any_x    = rise_x | fall_x;
   assign pol_ok   = ccnt_q == 2'h0 || (ccnt_q == 2'h1 && rise_x != first_crossing_polarity)
                     || (ccnt_q == 2'h2 && rise_x == first_crossing_polarity);
   assign take_x   = any_x && pol_ok && ccnt_q != 2'h3;
   assign below_band = 9'(cur) + 9'(hyst_q) <= 9'(middle_ref_level);
   assign above_band = 9'(cur) >= 9'(middle_ref_level) + 9'(hyst_q);
   assign rem_sh   = {div_rem_q[SQ_W-2:0], div_quo_q[SQ_W-1]};
   assign trial    = cycle_rms | SAMP_W'(1 << bit_q);
   // Handshake outputs
   assign sample_ready = state_q == S_LOAD;
   assign busy         = state_q != S_IDLE;
   assign done         = state_q == S_DONE;

   // ************************************************************
   // Memories
   // ************************************************************
   // Record store
   always_ff @(posedge clk) begin
      if (state_q == S_LOAD && sample_valid) begin
         rec_mem[idx_q[ADDR_W-1:0]] <= sample_data;
      end
   end
   // Histogram clear and count
   always_ff @(posedge clk) begin
      if (state_q == S_CLEAR) begin
         hist_mem[bin] <= '0;
      end else if (state_q == S_LOAD && sample_valid) begin
         hist_mem[sample_data] <= hist_mem[sample_data] + 1'b1;
      end
   end
   // Trigger position capture
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         time_zero <= '0;
      end else if (trigger_strobe) begin
         time_zero <= {1'b0, pretrigger_sample_index, {FRAC_W{1'b0}}} + TZ_W'(trigger_fraction_offset);
      end
   end

   // ************************************************************
   // Sequencer and results
   // ************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= S_IDLE;
         idx_q <= '0; zs_q <= '0; ze_q <= '0;
         min_q <= SAMP_MAX; max_q <= SAMP_MIN; prev_q <= '0; zs_samp_q <= '0; hyst_q <= '0;
         hi_cnt_q <= '0; lo_cnt_q <= '0; hi_bin_q <= '0; lo_bin_q <= '0;
         rise_arm_q <= 1'b1; fall_arm_q <= 1'b1; ccnt_q <= '0;
         area_acc_q <= '0; cyc_acc_q <= '0; sq_acc_q <= '0;
         div_rem_q <= '0; div_quo_q <= '0; div_den_q <= '0; bit_q <= '0;
         high_level <= '0; low_level <= '0; amplitude <= '0;
         upper_ref_level <= '0; middle_ref_level <= '0; lower_ref_level <= '0; second_middle_ref_level <= '0;
         first_center_crossing <= '0; second_center_crossing <= '0; third_center_crossing <= '0;
         first_crossing_polarity <= 1'b0; cycle_valid <= 1'b0; cycle_begin <= '0; cycle_finish <= '0;
         burst_first_crossing <= '0; burst_last_crossing <= '0; burst_width <= '0;
         area <= '0; cycle_area <= '0; cycle_mean <= '0; cycle_rms <= '0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  state_q <= S_CLEAR;
                  idx_q <= '0;
                  zs_q <= gate_enable ? left_cursor : '0;
                  ze_q <= gate_enable ? right_cursor : ADDR_W'(record_size - 1'b1);
                  min_q <= SAMP_MAX;
                  max_q <= SAMP_MIN;
               end
            end
            S_CLEAR: begin
               idx_q <= idx_q + 1'b1;
               if (bin == BIN_LAST) begin
                  state_q <= S_LOAD;
                  idx_q <= '0;
               end
            end
            S_LOAD: begin
               if (sample_valid) begin
                  idx_q <= idx_q + 1'b1;
                  // Zone extremes
                  if (in_zone && sample_data > max_q) max_q <= sample_data;
                  if (in_zone && sample_data < min_q) min_q <= sample_data;
                  if (idx_q == record_size - 1'b1) begin
                     state_q <= S_HIST;
                     idx_q <= '0;
                     hi_cnt_q <= '0; lo_cnt_q <= '0;
                     hi_bin_q <= '0; lo_bin_q <= '0;
                  end
               end
            end
            S_HIST: begin
               // Upper half: >= keeps the farther tie; lower half: > keeps it
               if (bin > mid_bin && bin_cnt >= hi_cnt_q) begin
                  hi_cnt_q <= bin_cnt;
                  hi_bin_q <= bin;
               end
               if (bin < mid_bin && bin_cnt > lo_cnt_q) begin
                  lo_cnt_q <= bin_cnt;
                  lo_bin_q <= bin;
               end
               idx_q <= idx_q + 1'b1;
               if (bin == BIN_LAST) state_q <= S_LEVEL;
            end
            S_LEVEL: begin
               if (!hist_mode) begin
                  high_level <= max_q;
                  low_level <= min_q;
                  amplitude <= max_q - min_q;
               end else if (mid_cnt > hi_cnt_q || mid_cnt > lo_cnt_q) begin
                  high_level <= mid_bin;
                  low_level <= mid_bin;
                  amplitude <= '0;
               end else begin
                  high_level <= hi_bin_q;
                  low_level <= lo_bin_q;
                  amplitude <= hi_bin_q - lo_bin_q;
               end
               state_q <= S_REFS;
            end
            S_REFS: begin
               // Reference levels from programmed percentages
               upper_ref_level <= pct_level(low_level, amplitude, upper_ref_pct);
               middle_ref_level <= pct_level(low_level, amplitude, middle_ref_pct);
               lower_ref_level <= pct_level(low_level, amplitude, lower_ref_pct);
               second_middle_ref_level <= pct_level(low_level, amplitude, second_middle_ref_pct);
               hyst_q <= pct_level(SAMP_MIN, amplitude, HYST_PCT);
               idx_q <= (ADDR_W+1)'(zs_q);
               rise_arm_q <= 1'b1; fall_arm_q <= 1'b1; ccnt_q <= '0;
               area_acc_q <= '0; cyc_acc_q <= '0; sq_acc_q <= '0;
               state_q <= S_SCAN;
            end
            S_SCAN: begin
               prev_q <= cur;
               if (first_pt) zs_samp_q <= cur;
               // Arming: any crossing disarms, band exit rearms
               rise_arm_q <= (rise_arm_q && !any_x) || below_band;
               fall_arm_q <= (fall_arm_q && !any_x) || above_band;
               if (!first_pt) area_acc_q <= area_acc_q + ACC_W'(9'(prev_q) + 9'(cur));
               if (!first_pt && (ccnt_q == 2'h1 || ccnt_q == 2'h2)) begin
                  cyc_acc_q <= cyc_acc_q + ACC_W'(9'(prev_q) + 9'(cur));
                  sq_acc_q <= sq_acc_q + SQ_W'(17'(16'(prev_q) * 16'(prev_q)) + 17'(16'(cur) * 16'(cur)));
               end
               if (any_x && ccnt_q != 2'h3) burst_last_crossing <= idx_q[ADDR_W-1:0];
               if (take_x) begin
                  ccnt_q <= ccnt_q + 1'b1;
                  case (ccnt_q)
                     2'h0: begin
                        first_center_crossing <= idx_q[ADDR_W-1:0];
                        first_crossing_polarity <= rise_x;
                     end
                     2'h1: second_center_crossing <= idx_q[ADDR_W-1:0];
                     default: third_center_crossing <= idx_q[ADDR_W-1:0];
                  endcase
               end
               idx_q <= idx_q + 1'b1;
               if (last_idx) state_q <= S_POST;
            end
            S_POST: begin
               area <= (zs_q == ze_q) ? AREA_W'(zs_samp_q)
                       : AREA_W'((AREA_W'(area_acc_q) * AREA_W'(sample_interval)) >> 1);
               burst_first_crossing <= first_center_crossing;
               burst_width <= (ccnt_q == 2'h0) ? '0 : burst_last_crossing - first_center_crossing;
               cycle_valid <= ccnt_q == 2'h3;
               if (ccnt_q == 2'h3) begin
                  cycle_begin <= first_center_crossing;
                  cycle_finish <= third_center_crossing;
                  cycle_area <= AREA_W'((AREA_W'(cyc_acc_q) * AREA_W'(sample_interval)) >> 1);
                  div_rem_q <= '0;
                  div_quo_q <= SQ_W'(cyc_acc_q);
                  div_den_q <= SQ_W'({third_center_crossing - first_center_crossing, 1'b0});
                  bit_q <= DIV_TOP;
                  state_q <= S_DIV1;
               end else begin
                  // Empty cycle falls back to the zone start sample
                  cycle_begin <= zs_q;
                  cycle_finish <= zs_q;
                  cycle_area <= AREA_W'(zs_samp_q);
                  cycle_mean <= zs_samp_q;
                  cycle_rms <= zs_samp_q;
                  state_q <= S_DONE;
               end
            end
            S_DIV1, S_DIV2: begin
               // Restoring divide, one quotient bit per clock
               if (rem_sh >= div_den_q) begin
                  div_rem_q <= rem_sh - div_den_q;
                  div_quo_q <= {div_quo_q[SQ_W-2:0], 1'b1};
               end else begin
                  div_rem_q <= rem_sh;
                  div_quo_q <= {div_quo_q[SQ_W-2:0], 1'b0};
               end
               bit_q <= bit_q - 1'b1;
               if (bit_q == '0) begin
                  if (state_q == S_DIV1) begin
                     cycle_mean <= SAMP_W'({div_quo_q[SQ_W-2:0], rem_sh >= div_den_q});
                     div_rem_q <= '0;
                     div_quo_q <= sq_acc_q;
                     bit_q <= DIV_TOP;
                     state_q <= S_DIV2;
                  end else begin
                     cycle_rms <= '0;
                     bit_q <= SQRT_TOP;
                     state_q <= S_SQRT;
                  end
               end
            end
            S_SQRT: begin
               // Bitwise square root of the mean square
               if (SQ_W'(16'(trial) * 16'(trial)) <= div_quo_q) cycle_rms <= trial;
               bit_q <= bit_q - 1'b1;
               if (bit_q == '0) state_q <= S_DONE;
            end
            default: begin  // Done and stray states return to idle
               state_q <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// [bench/wme_record_model.sv]
// Record memory model: streams stored samples to the engine.
// Assumes the bench fills mem before each measurement starts.
`timescale 1ns/10ps
module wme_record_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       slow,
   input  wire logic       sample_ready,
   output logic            sample_valid,
   output logic [7:0]      sample_data
);
   logic [7:0] mem [1024];
   logic [9:0] idx_q;
   logic       hold_q;

   // Advance per accepted sample, restart outside load, stall a cycle when slow
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         idx_q  <= 10'h000;
         hold_q <= 1'b0;
      end else begin
         hold_q <= slow & sample_valid & sample_ready;
         idx_q  <= !sample_ready ? 10'h000 : idx_q + 10'(sample_valid & sample_ready);
      end
   end

   // Stalled data shows the inverse so stale values never pass
   assign sample_valid = !hold_q;
   assign sample_data  = hold_q ? ~mem[idx_q] : mem[idx_q];
endmodule

// [bench/wme_engine_properties.sv]
// Checker of the measurement engine port behaviour.
// Assumes binding onto wme_engine, one clock domain.
`timescale 1ns/10ps
module wme_engine_properties (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        start,
   input wire logic        trigger_strobe,
   input wire logic [9:0]  pretrigger_sample_index,
   input wire logic [8:0]  trigger_fraction_offset,
   input wire logic        sample_ready,
   input wire logic        busy,
   input wire logic        done,
   input wire logic [7:0]  high_level,
   input wire logic [7:0]  low_level,
   input wire logic [7:0]  amplitude,
   input wire logic [9:0]  first_center_crossing,
   input wire logic [9:0]  third_center_crossing,
   input wire logic        cycle_valid,
   input wire logic [9:0]  cycle_begin,
   input wire logic [9:0]  cycle_finish,
   input wire logic [9:0]  burst_first_crossing,
   input wire logic [9:0]  burst_last_crossing,
   input wire logic [9:0]  burst_width,
   input wire logic [18:0] time_zero
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   AST_START_BUSY: assert property (!busy && start |=> busy) else $error("start not taken");
   AST_DONE_PULSE: assert property (done |=> !done && !busy) else $error("done not single");
   AST_HELD: assert property (!busy ##1 !busy |-> $stable(amplitude) && $stable(cycle_begin))
      else $error("result moved while idle");
   AST_READY_BUSY: assert property (sample_ready |-> busy) else $error("ready while idle");
   AST_AMPLITUDE: assert property (done |-> amplitude == high_level - low_level) else $error("bad amplitude");
   AST_LEVELS: assert property (done |-> high_level >= low_level) else $error("levels reversed");
   AST_CYCLE: assert property (done && cycle_valid |-> cycle_begin == first_center_crossing &&
      cycle_finish == third_center_crossing) else $error("cycle bounds wrong");
   AST_BURST: assert property (done && cycle_valid |-> burst_width == burst_last_crossing - burst_first_crossing)
      else $error("burst width wrong");
   AST_TIME_ZERO: assert property (trigger_strobe |=> time_zero == 19'({$past(pretrigger_sample_index), 8'h00}) +
      19'($past(trigger_fraction_offset))) else $error("time zero wrong");

   // Main scenarios reached
   cover property (done && cycle_valid);
   cover property (done && !cycle_valid);
   cover property (done && amplitude == 8'h00);
endmodule

bind wme_engine wme_engine_properties u_props (.*);

// [bench/wme_engine_tb_top.sv]
// Self-checking bench: random square waves and flat records through the engine.
// Assumes the record model feeds samples; expectations come from bench code.
`timescale 1ns/10ps
module wme_engine_tb_top;
   import wme_pkg::*;
   logic        clk = 1'b0, reset = 1'b1, start = 1'b0, hist_mode = 1'b0, gate_enable = 1'b0;
   logic        trigger_strobe = 1'b0, slow = 1'b0, sample_valid, sample_ready, busy, done;
   logic        first_crossing_polarity, cycle_valid;
   logic [10:0] record_size = 11'h001;
   logic [9:0]  left_cursor = 10'h000, right_cursor = 10'h000, pretrigger_sample_index = 10'h000;
   logic [9:0]  first_center_crossing, second_center_crossing, third_center_crossing, cycle_begin, cycle_finish;
   logic [9:0]  burst_first_crossing, burst_last_crossing, burst_width;
   logic [6:0]  upper_ref_pct = 7'h5A, middle_ref_pct = 7'h32, lower_ref_pct = 7'h0A, second_middle_ref_pct = 7'h32;
   logic [15:0] sample_interval = 16'h0001;
   logic [8:0]  trigger_fraction_offset = 9'h000;
   logic [7:0]  sample_data, high_level, low_level, amplitude, upper_ref_level, middle_ref_level;
   logic [7:0]  lower_ref_level, second_middle_ref_level, cycle_mean, cycle_rms;
   logic [35:0] area, cycle_area;
   logic [18:0] time_zero;
   logic [31:0] lf = 32'h3409B706;
   int          w [1024];
   int          errors = 0;
   int          compares = 0;

   wme_engine DUT (.*);
   wme_record_model mdl (.clk(clk), .reset(reset), .slow(slow), .sample_ready(sample_ready),
                         .sample_valid(sample_valid), .sample_data(sample_data));

   // 20 MHz clock
   always #25 clk = ~clk;

   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction

   // Percent pick with full-scale and zero corners
   function automatic logic [6:0] pk(input int k);
      return (k == 3) ? 7'h64 : (k == 4) ? 7'h00 : 7'(rnd() % 101);
   endfunction

   // Sum of adjacent pair sums over integer bounds
   function automatic longint ps(input int a, input int b);
      ps = 0;
      for (int i = a; i < b; i++) ps += w[i] + w[i+1];
   endfunction

   // Sum of adjacent pair squares, and floor square root
   function automatic longint qs(input int a, input int b);
      qs = 0;
      for (int i = a; i < b; i++) qs += w[i] * w[i] + w[i+1] * w[i+1];
   endfunction

   function automatic int isq(input longint v);
      int r;
      r = 0;
      while ((r + 1) * (r + 1) <= v) r++;
      return r;
   endfunction

   task automatic chk(input logic [35:0] s, input logic [35:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic test_done();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // One measurement: flat records for k<3, square waves after
   task automatic run(input int k);
      int n, s, e, lo, hi, p, mn, mx, md, ub, lb, a, m, hy, np, fp, pol, rr, rf;
      int c[3], cnt[256];
      n = (k == 0) ? 1 : 16 + rnd() % 48;
      lo = rnd() % 100;
      hi = lo + 4 + rnd() % 150;
      p = 2 + rnd() % 6;
      for (int i = 0; i < n; i++) begin
         w[i] = (k < 3 || (i / p + k) % 2 == 0) ? lo : hi;
         mdl.mem[i] = 8'(w[i]);
      end
      hist_mode = (k == 2) || (k > 2 && k % 2 == 1);
      gate_enable = (k == 1) || (k > 2 && !hist_mode && rnd() % 2);
      s = gate_enable ? rnd() % n : 0;
      e = (k == 1) ? s : gate_enable ? s + rnd() % (n - s) : n - 1;
      record_size = 11'(n);
      left_cursor = 10'(s);
      right_cursor = 10'(e);
      upper_ref_pct = pk(k);
      middle_ref_pct = pk(k);
      lower_ref_pct = pk(k);
      second_middle_ref_pct = pk(k);
      sample_interval = 16'(rnd());
      slow = rnd() % 2;
      pretrigger_sample_index = 10'(rnd());
      trigger_fraction_offset = 9'(rnd() % 257);
      trigger_strobe = 1'b1;
      @(negedge clk);
      trigger_strobe = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (int t = 0; t < 3000 && !done; t++) @(negedge clk);
      // Levels: zone extremes, or histogram peaks split at the midpoint
      mn = 255;
      mx = 0;
      for (int i = s; i <= e; i++) begin
         if (w[i] < mn) mn = w[i];
         if (w[i] > mx) mx = w[i];
      end
      ub = mx;
      lb = mn;
      if (hist_mode) begin
         md = (mn + mx) / 2;
         ub = md;
         lb = md;
         cnt = '{default: 0};
         for (int i = 0; i < n; i++) cnt[w[i]]++;
         for (int b = md + 1; b < 256; b++) if (cnt[b] > 0 && cnt[b] >= cnt[ub]) ub = b;
         for (int b = md - 1; b >= 0; b--) if (cnt[b] > 0 && cnt[b] >= cnt[lb]) lb = b;
         if (ub == md || lb == md) begin
            ub = md;
            lb = md;
         end
      end
      a = ub - lb;
      m = lb + a * middle_ref_pct / 100;
      // Alternating middle crossings with hysteresis rearm
      hy = a / 10;
      np = 0;
      rr = 1;
      rf = 1;
      fp = 0;
      for (int i = s + 1; i <= e && np < 3; i++) begin
         pol = (rr && w[i-1] < m && w[i] >= m) ? 1 : (rf && w[i-1] >= m && w[i] < m) ? 0 : 2;
         if (pol < 2) begin
            rr = 0;
            rf = 0;
            if (np == 0) fp = pol;
            if (np != 1 ? pol == fp : pol != fp) begin
               c[np] = i;
               np++;
            end
         end
         if (w[i] <= m - hy) rr = 1;
         if (w[i] >= m + hy) rf = 1;
      end
      chk(done, 1'b1);
      chk(high_level, ub);
      chk(low_level, lb);
      chk(amplitude, a);
      chk(upper_ref_level, lb + a * upper_ref_pct / 100);
      chk(middle_ref_level, m);
      chk(lower_ref_level, lb + a * lower_ref_pct / 100);
      chk(second_middle_ref_level, lb + a * second_middle_ref_pct / 100);
      chk(area, (s == e) ? w[s] : 36'(ps(s, e) * sample_interval / 2));
      chk(time_zero, {pretrigger_sample_index, 8'h00} + trigger_fraction_offset);
      chk(cycle_valid, np == 3);
      if (np == 3) begin
         chk(first_crossing_polarity, fp);
         chk(first_center_crossing, c[0]);
         chk(second_center_crossing, c[1]);
         chk(cycle_finish, c[2]);
         chk(cycle_begin, c[0]);
         chk(burst_first_crossing, c[0]);
         chk(burst_width, c[2] - c[0]);
         chk(cycle_area, 36'(ps(c[0], c[2]) * sample_interval / 2));
         chk(cycle_mean, ps(c[0], c[2]) / (2 * (c[2] - c[0])));
         chk(cycle_rms, isq(qs(c[0], c[2]) / (2 * (c[2] - c[0]))));
      end else begin
         chk(cycle_begin, s);
         chk(cycle_finish, s);
         chk(cycle_area, w[s]);
         chk(cycle_mean, w[s]);
         chk(cycle_rms, w[s]);
      end
   endtask

   // Watchdog against a hung measurement
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      test_done();
   end

   initial begin
      repeat (10) @(negedge clk);
      reset = 1'b0;
      for (int k = 0; k < 14; k++) run(k);
      test_done();
   end
endmodule
